// ---- verilog/hbc_consts.vh ----
`ifndef HBC_CONSTS_VH
`define HBC_CONSTS_VH

// Register byte offsets
`define HBC_ADDR_W 12
`define HBC_OFS_MODE 12'h000
`define HBC_OFS_CTRL 12'h004
`define HBC_OFS_TEST0 12'h008
`define HBC_OFS_SNOOP 12'h00C
`define HBC_OFS_STAT 12'h010

// Mode register fields
`define HBC_MODE_PD 3
`define HBC_MODE_FC1 4
`define HBC_MODE_FC2 5
`define HBC_MODE_RST 8'h00

// Control register fields
`define HBC_CTRL_BM 6
`define HBC_CTRL_RST 8'h00

// Test register zero fields
`define HBC_T0_TT1 1
`define HBC_T0_CLB 0
`define HBC_T0_RST 8'h00

// Snoop register fields
`define HBC_SN_LO 0
`define HBC_SN_HI 1
`define HBC_SN_PURE 2
`define HBC_SN_RST 8'h00

// Status register fields
`define HBC_ST_MASTER 0
`define HBC_ST_MODE_LO 1
`define HBC_ST_MODE_HI 2
`define HBC_ST_BIG 3
`define HBC_ST_RSVD 4
`define HBC_ST_NXTRDY 5
`define HBC_ST_BALLOW 6
`define HBC_ST_VALID 7

// Bus modes, numbered one less than the mode number
`define HBC_BM1 2'h0
`define HBC_BM2 2'h1
`define HBC_BM3 2'h2
`define HBC_BM4 2'h3

// Strap select pattern that is reserved
`define HBC_BS_RSVD 3'h3
`define HBC_BS_STYLE 2
`define HBC_BS_BIG 1
`define HBC_BS_ODD 0

// Cycles after reset release before the straps are caught
`define HBC_STRAP_DLY 2'h3

// Synchronised pin vector layout
`define HBC_SY_W 7
`define HBC_SY_CS 3
`define HBC_SY_BI 4
`define HBC_SY_PA 5
`define HBC_SY_TST 6

`endif

// ---- verilog/hbc_sync.v ----
`timescale 1ns/1ns
// Two-stage synchroniser, idle level high for active-low pins
module hbc_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
        end else begin
          s1_r <= d_i[g];
          s2_r <= s1_r;
        end
      end
      assign q_o[g] = s2_r;
    end
  endgenerate
endmodule // hbc_sync

// ---- verilog/hbc_host_bus_ctrl.v ----
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "hbc_consts.vh"
module hbc_host_bus_ctrl (
  input wire clk_i,
  input wire resetn_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`HBC_ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Core side, same clock
  input wire master_i,
  input wire fetch_cycle_i,
  input wire next_fetch_i,
  input wire line_burst_i,
  output wire burst_allowed_o,
  output wire next_addr_ready_o,
  output wire [1:0] bus_mode_o,
  output wire big_endian_o,
  // Pins, asynchronous
  input wire [2:0] bus_mode_select_pins_i,
  input wire chip_select_n_i,
  input wire burst_inhibit_n_i,
  input wire function_code_line2_i,
  input wire test_mode_n_i,
  // Pins, outputs, all but fetch_n_o with enables (enable low drives)
  output wire [1:0] function_code_lines_o,
  output wire [1:0] function_code_lines_oe_n_o,
  output wire function_code_line2_o,
  output wire function_code_line2_oe_n_o,
  output wire [1:0] snoop_level_outputs_o,
  output wire snoop_level_outputs_oe_n_o,
  output wire master_n_o,
  output wire master_oe_n_o,
  output wire fetch_n_o,
  output wire cache_burst_request_n_o,
  output wire cache_burst_request_oe_n_o,
  output wire burst_inhibit_n_o,
  output wire burst_inhibit_oe_n_o
);

  // Reset release through two flops
  reg rst_s1_r;
  reg rst_n_r;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Pin synchronisers
  wire [`HBC_SY_W-1:0] sy_d;
  wire [`HBC_SY_W-1:0] sy_q;
  assign sy_d = {test_mode_n_i, function_code_line2_i, burst_inhibit_n_i,
                 chip_select_n_i, bus_mode_select_pins_i};

  hbc_sync #(
    .W(`HBC_SY_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_r),
    .d_i(sy_d),
    .q_o(sy_q)
  );

  wire [2:0] bs_s = sy_q[2:0];
  wire cs_n_s = sy_q[`HBC_SY_CS];
  wire bi_n_s = sy_q[`HBC_SY_BI];
  wire pa_n_s = sy_q[`HBC_SY_PA];
  wire tst_n_s = sy_q[`HBC_SY_TST];

  // Straps caught once the synchroniser holds settled pin levels
  reg [1:0] strap_cnt_r;
  reg strap_ok_r;
  reg [1:0] mode_r;
  reg big_r;
  reg rsvd_r;
  reg [1:0] mode_nxt;
  always @* begin
    case ({bs_s[`HBC_BS_STYLE], bs_s[`HBC_BS_ODD]})
      2'h3: mode_nxt = `HBC_BM1;
      2'h2: mode_nxt = `HBC_BM2;
      2'h1: mode_nxt = `HBC_BM3;
      default: mode_nxt = `HBC_BM4;
    endcase
  end

  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      strap_cnt_r <= 2'h0;
      strap_ok_r <= 1'b0;
      mode_r <= `HBC_BM4;
      big_r <= 1'b0;
      rsvd_r <= 1'b0;
    end else if (!strap_ok_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == `HBC_STRAP_DLY) begin
        // Latched once; later pin changes are ignored
        strap_ok_r <= 1'b1;
        mode_r <= mode_nxt;
        big_r <= bs_s[`HBC_BS_BIG];
        rsvd_r <= (bs_s == `HBC_BS_RSVD);
      end
    end
  end

  // Registers
  reg [7:0] mode_reg_r;
  reg [7:0] ctrl_reg_r;
  reg [7:0] test0_reg_r;
  reg [7:0] snoop_reg_r;
  reg [31:0] prdata_r;
  reg pready_r;
  reg pslverr_r;
  reg [31:0] rdata_nxt;
  reg hit_nxt;
  wire [7:0] stat_w;

  wire setup = psel_i & ~penable_i;
  wire wr_en = psel_i & penable_i & pready_r & pwrite_i & ~pslverr_r;

  always @* begin
    rdata_nxt = 32'h00000000;
    hit_nxt = 1'b1;
    case (paddr_i)
      `HBC_OFS_MODE: rdata_nxt[7:0] = mode_reg_r;
      `HBC_OFS_CTRL: rdata_nxt[7:0] = ctrl_reg_r;
      `HBC_OFS_TEST0: rdata_nxt[7:0] = test0_reg_r;
      `HBC_OFS_SNOOP: rdata_nxt[7:0] = snoop_reg_r;
      `HBC_OFS_STAT: rdata_nxt[7:0] = stat_w;
      default: hit_nxt = 1'b0;
    endcase
  end

  reg [31:0] prdata_nxt;
  reg pready_nxt;
  reg pslverr_nxt;

  always @* begin
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup) begin
      // Answer prepared in setup, given in the single access cycle
      prdata_nxt = pwrite_i ? 32'h00000000 : rdata_nxt;
      pready_nxt = 1'b1;
      pslverr_nxt = ~hit_nxt | (pwrite_i & (paddr_i == `HBC_OFS_STAT));
    end
  end

  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  reg [7:0] mode_reg_nxt;
  reg [7:0] ctrl_reg_nxt;
  reg [7:0] test0_reg_nxt;
  reg [7:0] snoop_reg_nxt;

  always @* begin
    mode_reg_nxt = mode_reg_r;
    ctrl_reg_nxt = ctrl_reg_r;
    test0_reg_nxt = test0_reg_r;
    snoop_reg_nxt = snoop_reg_r;
    if (wr_en) begin
      case (paddr_i)
        `HBC_OFS_MODE: mode_reg_nxt = pwdata_i[7:0];
        `HBC_OFS_CTRL: ctrl_reg_nxt = pwdata_i[7:0];
        `HBC_OFS_TEST0: test0_reg_nxt = pwdata_i[7:0];
        `HBC_OFS_SNOOP: snoop_reg_nxt = pwdata_i[7:0];
        default: snoop_reg_nxt = snoop_reg_r;
      endcase
    end
  end

  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_reg_r <= `HBC_MODE_RST;
      ctrl_reg_r <= `HBC_CTRL_RST;
      test0_reg_r <= `HBC_T0_RST;
      snoop_reg_r <= `HBC_SN_RST;
    end else begin
      mode_reg_r <= mode_reg_nxt;
      ctrl_reg_r <= ctrl_reg_nxt;
      test0_reg_r <= test0_reg_nxt;
      snoop_reg_r <= snoop_reg_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;

  // Pin behaviour
  wire pd_bit = mode_reg_r[`HBC_MODE_PD];
  wire fc1_bit = mode_reg_r[`HBC_MODE_FC1];
  wire fc2_bit = mode_reg_r[`HBC_MODE_FC2];
  wire bm_bit = ctrl_reg_r[`HBC_CTRL_BM];
  wire clb_en = test0_reg_r[`HBC_T0_CLB];
  wire tt1_bit = test0_reg_r[`HBC_T0_TT1];
  wire pure_snoop = snoop_reg_r[`HBC_SN_PURE];
  wire zmode = ~tst_n_s;
  wire own = master_i & ~zmode;
  wire mode1 = (mode_r == `HBC_BM1);
  wire mode4 = (mode_r == `HBC_BM4);
  wire burst_pin = mode1 | (mode4 & clb_en);

  reg [1:0] fc_r;
  reg [1:0] fc_oe_n_r;
  reg fc2_r;
  reg fc2_oe_n_r;
  reg [1:0] snoop_r;
  reg snoop_oe_n_r;
  reg master_n_r;
  reg master_oe_n_r;
  reg fetch_n_r;
  reg cbr_r;
  reg cbr_oe_n_r;
  reg bi_r;
  reg bi_oe_n_r;
  reg nxt_rdy_r;
  reg ballow_r;
  reg [1:0] fc_nxt;
  reg [1:0] fc_oe_n_nxt;
  reg fc2_nxt;
  reg fc2_oe_n_nxt;
  reg [1:0] snoop_nxt;
  reg snoop_oe_n_nxt;
  reg master_n_nxt;
  reg master_oe_n_nxt;
  reg fetch_n_nxt;
  reg cbr_nxt;
  reg cbr_oe_n_nxt;
  reg bi_nxt;
  reg bi_oe_n_nxt;
  reg nxt_rdy_nxt;
  reg ballow_nxt;

  always @* begin
    // Program/data status, or program when the option is off
    fc_nxt[0] = pd_bit ? fetch_cycle_i : 1'b1;
    fc_nxt[1] = bm_bit & fc1_bit;
    fc_oe_n_nxt = {2{~own}};
    fc2_nxt = fc2_bit;
    fc2_oe_n_nxt = ~own | bm_bit;
    nxt_rdy_nxt = bm_bit & ~pa_n_s;
    snoop_nxt = {snoop_reg_r[`HBC_SN_HI], snoop_reg_r[`HBC_SN_LO]};
    snoop_oe_n_nxt = zmode | ~(master_i | pure_snoop);
    master_n_nxt = ~master_i;
    master_oe_n_nxt = zmode;
    fetch_n_nxt = ~next_fetch_i;
    if (burst_pin) begin
      cbr_nxt = ~line_burst_i;
    end else begin
      cbr_nxt = ~tt1_bit;
    end
    // Mode 4 without line burst keeps the transfer-type meaning
    cbr_oe_n_nxt = ~own;
    // Slave side: refuse bursts while selected, except in mode 1 where the pin is held high
    bi_nxt = mode1 ? 1'b1 : cs_n_s;
    bi_oe_n_nxt = master_i | zmode;
    // Master side: fall back to single transfers when inhibited; in mode 1 a low pin allows bursts instead
    ballow_nxt = master_i & ((mode1 & ~bi_n_s) | (~mode1 & bi_n_s));
  end

  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fc_r <= 2'h0;
      fc_oe_n_r <= 2'h3;
      fc2_r <= 1'b0;
      fc2_oe_n_r <= 1'b1;
      snoop_r <= 2'h0;
      snoop_oe_n_r <= 1'b1;
      master_n_r <= 1'b1;
      master_oe_n_r <= 1'b0;
      fetch_n_r <= 1'b1;
      cbr_r <= 1'b1;
      cbr_oe_n_r <= 1'b1;
      bi_r <= 1'b1;
      bi_oe_n_r <= 1'b1;
      nxt_rdy_r <= 1'b0;
      ballow_r <= 1'b0;
    end else begin
      fc_r <= fc_nxt;
      fc_oe_n_r <= fc_oe_n_nxt;
      fc2_r <= fc2_nxt;
      fc2_oe_n_r <= fc2_oe_n_nxt;
      snoop_r <= snoop_nxt;
      snoop_oe_n_r <= snoop_oe_n_nxt;
      master_n_r <= master_n_nxt;
      master_oe_n_r <= master_oe_n_nxt;
      fetch_n_r <= fetch_n_nxt;
      cbr_r <= cbr_nxt;
      cbr_oe_n_r <= cbr_oe_n_nxt;
      bi_r <= bi_nxt;
      bi_oe_n_r <= bi_oe_n_nxt;
      nxt_rdy_r <= nxt_rdy_nxt;
      ballow_r <= ballow_nxt;
    end
  end

  assign stat_w = {strap_ok_r, ballow_r, nxt_rdy_r, rsvd_r, big_r, mode_r, master_i};

  assign function_code_lines_o = fc_r;
  assign function_code_lines_oe_n_o = fc_oe_n_r;
  assign function_code_line2_o = fc2_r;
  assign function_code_line2_oe_n_o = fc2_oe_n_r;
  assign snoop_level_outputs_o = snoop_r;
  assign snoop_level_outputs_oe_n_o = snoop_oe_n_r;
  assign master_n_o = master_n_r;
  assign master_oe_n_o = master_oe_n_r;
  assign fetch_n_o = fetch_n_r;
  assign cache_burst_request_n_o = cbr_r;
  assign cache_burst_request_oe_n_o = cbr_oe_n_r;
  assign burst_inhibit_n_o = bi_r;
  assign burst_inhibit_oe_n_o = bi_oe_n_r;
  assign next_addr_ready_o = nxt_rdy_r;
  assign burst_allowed_o = ballow_r;
  assign bus_mode_o = mode_r;
  assign big_endian_o = big_r;

endmodule // hbc_host_bus_ctrl

// ---- bench/hbc_mem_model.sv ----
`timescale 1ns/1ns
// Memory side of the shared inhibit pin; the pin is pulled up when nobody drives it
module hbc_mem_model (
  input wire clk_i,
  input wire inhibit_i,
  input wire dev_n_i,
  input wire dev_oe_n_i,
  output wire pin_o
);
  reg drive_r = 1'b0;
  always @(posedge clk_i) begin
    drive_r <= inhibit_i;
  end
  assign pin_o = !dev_oe_n_i ? dev_n_i : !drive_r;
endmodule // hbc_mem_model

// ---- bench/hbc_host_bus_ctrl_properties.sv ----
`timescale 1ns/1ns
`include "hbc_consts.vh"
module hbc_props (
  input wire clk_i,
  input wire resetn_i,
  input wire master_i,
  input wire test_mode_n_i,
  input wire next_fetch_i,
  input wire line_burst_i,
  input wire chip_select_n_i,
  input wire master_n_o,
  input wire master_oe_n_o,
  input wire fetch_n_o,
  input wire [1:0] function_code_lines_oe_n_o,
  input wire cache_burst_request_n_o,
  input wire cache_burst_request_oe_n_o,
  input wire burst_inhibit_n_o,
  input wire burst_inhibit_oe_n_o,
  input wire [1:0] bus_mode_o,
  input wire big_endian_o
);
  reg [3:0] up_r;
  // Hold off until straps and synchronisers have settled
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) up_r <= 4'h0;
    else if (up_r != 4'hF) up_r <= up_r + 4'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i || up_r != 4'hF);
  sequence s_slave_cs;
    (!chip_select_n_i && !master_i && test_mode_n_i && bus_mode_o != `HBC_BM1) [*4];
  endsequence
  a_master_low: assert property (master_i |=> !master_n_o)
    else $error("master status not low");
  a_master_high: assert property (!master_i |=> master_n_o)
    else $error("master status not high");
  a_master_float: assert property (master_oe_n_o == !$past(test_mode_n_i, 3))
    else $error("master status enable wrong");
  a_idle_float: assert property (!master_i |=> function_code_lines_oe_n_o == 2'h3 &&
    cache_burst_request_oe_n_o) else $error("three-state line driven as slave");
  a_fetch_follow: assert property (fetch_n_o == !$past(next_fetch_i))
    else $error("fetch indicator wrong");
  a_inhibit_cs: assert property (s_slave_cs |-> !burst_inhibit_n_o && !burst_inhibit_oe_n_o)
    else $error("inhibit not asserted on chip select");
  a_inhibit_float: assert property (master_i |=> burst_inhibit_oe_n_o)
    else $error("inhibit driven while master");
  a_mode_static: assert property ($stable(bus_mode_o) && $stable(big_endian_o))
    else $error("strap decode changed");
  a_burst_req: assert property (master_i && line_burst_i && bus_mode_o == `HBC_BM1
    |=> !cache_burst_request_n_o) else $error("burst request missing");
endmodule // hbc_props
bind hbc_host_bus_ctrl hbc_props hbc_props_i (.clk_i(clk_i), .resetn_i(resetn_i),
  .master_i(master_i), .next_fetch_i(next_fetch_i), .line_burst_i(line_burst_i),
  .test_mode_n_i(test_mode_n_i),
  .chip_select_n_i(chip_select_n_i), .master_n_o(master_n_o), .master_oe_n_o(master_oe_n_o),
  .fetch_n_o(fetch_n_o), .function_code_lines_oe_n_o(function_code_lines_oe_n_o),
  .cache_burst_request_n_o(cache_burst_request_n_o),
  .cache_burst_request_oe_n_o(cache_burst_request_oe_n_o),
  .burst_inhibit_n_o(burst_inhibit_n_o), .burst_inhibit_oe_n_o(burst_inhibit_oe_n_o),
  .bus_mode_o(bus_mode_o), .big_endian_o(big_endian_o));

// ---- bench/tb_hbc_host_bus_ctrl.sv ----
`timescale 1ns/1ns
`include "hbc_consts.vh"
module tb_hbc_host_bus_ctrl;
  reg clk = 1'b0, resetn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, mst = 1'b0;
  reg fcy = 1'b0, nfet = 1'b0, lb = 1'b0, cs_n = 1'b1, fc2 = 1'b1, inh = 1'b0, e;
  reg tst_n = 1'b1;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000, q;
  reg [2:0] bs = 3'h0;
  reg [1:0] m;
  wire [31:0] prdata;
  wire prdy, perr, ball, nar, big, fc2o, fc2oe, snoe, mn, moe, fn, cbr, cbroe, bio, bioe, bip;
  wire [1:0] mode, fco, fcoe, sno;
  integer mismatches = 0, n_checks = 0, i;
  initial forever #10 clk = ~clk;
  hbc_host_bus_ctrl hbc_host_bus_ctrl_i (.clk_i(clk), .resetn_i(resetn), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(prdy), .pslverr_o(perr), .master_i(mst), .fetch_cycle_i(fcy),
    .next_fetch_i(nfet), .line_burst_i(lb), .burst_allowed_o(ball), .next_addr_ready_o(nar),
    .bus_mode_o(mode), .big_endian_o(big), .bus_mode_select_pins_i(bs),
    .chip_select_n_i(cs_n), .burst_inhibit_n_i(bip), .function_code_line2_i(fc2),
    .test_mode_n_i(tst_n), .function_code_lines_o(fco), .function_code_lines_oe_n_o(fcoe),
    .function_code_line2_o(fc2o), .function_code_line2_oe_n_o(fc2oe),
    .snoop_level_outputs_o(sno), .snoop_level_outputs_oe_n_o(snoe), .master_n_o(mn),
    .master_oe_n_o(moe), .fetch_n_o(fn), .cache_burst_request_n_o(cbr),
    .cache_burst_request_oe_n_o(cbroe), .burst_inhibit_n_o(bio),
    .burst_inhibit_oe_n_o(bioe));
  hbc_mem_model hbc_mem_model_i (.clk_i(clk), .inhibit_i(inh), .dev_n_i(bio),
    .dev_oe_n_i(bioe), .pin_o(bip));
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      n_checks = n_checks + 1;
      if (g !== x) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [7:0] d);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      @(posedge clk);
      while (prdy !== 1'b1 && n < 8) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 8) begin
        mismatches = mismatches + 1;
        print_verdict;
      end
      q = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] x, input xe);
    begin
      apb(1'b0, a, 8'h00);
      chk(q, x);
      chk(e, xe);
    end
  endtask
  task rst(input [2:0] b);
    begin
      @(posedge clk);
      bs <= b;
      resetn <= 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (12) @(posedge clk);
    end
  endtask
  // Pin inputs pass a synchroniser and the model adds one more stage
  task settle;
    begin
      repeat (6) @(posedge clk);
      @(negedge clk);
    end
  endtask
  initial begin
    for (i = 0; i < 8; i = i + 1) begin
      rst(i[2:0]);
      m = {~i[2], ~i[0]};
      @(negedge clk);
      chk(mode, m);
      chk(big, i[1]);
      rd(`HBC_OFS_STAT, {i == 3, i[1], m, 1'b0} | 8'h80, 1'b0);
    end
    $display("test straps done");
    rst(3'h0);
    for (i = 0; i < 16; i = i + 4) rd(i[11:0], 32'h00000000, 1'b0);
    apb(1'b0, 12'h014, 8'h00);
    chk(e, 1'b1);
    apb(1'b1, `HBC_OFS_STAT, 8'hFF);
    chk(e, 1'b1);
    cs_n <= 1'b0;
    settle;
    chk(mn, 1'b1);
    chk(fcoe, 2'h3);
    chk(cbroe, 1'b1);
    chk(bioe, 1'b0);
    chk(bio, 1'b0);
    chk(snoe, 1'b1);
    apb(1'b1, `HBC_OFS_MODE, 8'h38);
    apb(1'b1, `HBC_OFS_CTRL, 8'h40);
    apb(1'b1, `HBC_OFS_TEST0, 8'h02);
    apb(1'b1, `HBC_OFS_SNOOP, 8'h02);
    mst <= 1'b1;
    fcy <= 1'b1;
    fc2 <= 1'b0;
    nfet <= 1'b1;
    settle;
    chk(mn, 1'b0);
    chk(fcoe, 2'h0);
    chk(fco, 2'h3);
    chk(nar, 1'b1);
    chk(fc2oe, 1'b1);
    chk(cbr, 1'b0);
    chk(sno, 2'h2);
    chk(snoe, 1'b0);
    chk(fn, 1'b0);
    chk(bioe, 1'b1);
    chk(ball, 1'b1);
    @(posedge clk);
    fcy <= 1'b0;
    inh <= 1'b1;
    apb(1'b1, `HBC_OFS_TEST0, 8'h03);
    apb(1'b1, `HBC_OFS_CTRL, 8'h00);
    settle;
    chk(fco, 2'h0);
    chk(fc2oe, 1'b0);
    chk(fc2o, 1'b1);
    chk(cbr, 1'b1);
    chk(ball, 1'b0);
    @(posedge clk);
    mst <= 1'b0;
    apb(1'b1, `HBC_OFS_SNOOP, 8'h06);
    settle;
    chk(snoe, 1'b0);
    chk(cbroe, 1'b1);
    $display("test mode four done");
    rst(3'h5);
    mst <= 1'b1;
    lb <= 1'b1;
    settle;
    chk(cbr, 1'b0);
    @(posedge clk);
    mst <= 1'b0;
    settle;
    chk(bio, 1'b1);
    chk(bioe, 1'b0);
    @(posedge clk);
    mst <= 1'b1;
    tst_n <= 1'b0;
    settle;
    chk(moe, 1'b1);
    chk(mn, 1'b0);
    chk(fcoe, 2'h3);
    chk(cbroe, 1'b1);
    chk(snoe, 1'b1);
    chk(bioe, 1'b1);
    @(posedge clk);
    mst <= 1'b0;
    tst_n <= 1'b1;
    settle;
    chk(moe, 1'b0);
    chk(mn, 1'b1);
    $display("test mode one done");
    print_verdict;
  end
endmodule // tb_hbc_host_bus_ctrl
